// File: bench/fcsr_host_model.sv
/*
 * Serial host model that frames instructions for the register bank.
 * Assumes the extended single-line protocol and a clk of 25 MHz.
 */
`timescale 1ns/1ps
module fcsr_host_model (
    input wire logic clk,
    input wire logic [3:0] dq_out,
    input wire logic [3:0] dq_oe,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] dq_in
);
    logic [3:0] oe_seen;

    initial begin
        oe_seen = 4'h0;
        sclk = 1'b0;
        cs_n = 1'b1;
        dq_in = 4'b1110;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Each serial half period is four clk, so one bit takes 320 ns.
    // A released data line toggles so a stale level is never read back.
    task automatic xfer(input logic [7:0] op, input int nw,
                        input logic [15:0] wd, input int nr,
                        output logic [15:0] rd);
        logic [23:0] sh;
        int i;
        sh = {op, wd};
        rd = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        wt(4);
        for (i = 0; i < 8 + nw + nr; i++) begin
            dq_in[0] <= (i < 8 + nw) ? sh[23-i] : ~dq_in[0];
            wt(4);
            sclk <= 1'b1;
            wt(4);
            if (i >= 8 + nw) begin
                rd = {rd[14:0], dq_out[1]};
                oe_seen = dq_oe;
            end
            sclk <= 1'b0;
        end
        wt(4);
        cs_n <= 1'b1;
        dq_in[0] <= ~dq_in[0];
        wt(8);
    endtask
endmodule

// File: bench/flash_config_status_registers_tb.sv
/*
 * Self-checking bench for the register bank, driven through the host.
 * Assumes shortened boot counts and lengthened write counts set at the instance.
 */
`timescale 1ns/1ps
`include "fcsr_cfg.svh"
module flash_config_status_registers_tb;
    import fcsr_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wp_n = 1'b1;
    wire sclk;
    wire cs_n;
    wire [3:0] dq_in;
    wire [3:0] dq_out;
    wire [3:0] dq_oe;
    fcsr_work_s working_cfg;
    fcsr_prot_s protect_cfg;
    logic boot_done;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    logic [15:0] rd;

    always #20 clk = ~clk;

    fcsr_top #(.FULL_BOOT_CYC(200), .FAST_BOOT_CYC(50), .SR_WRITE_CYC(200),
        .NV_WRITE_CYC(600)) dut (.clk(clk),
        .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .wp_n(wp_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .working_cfg(working_cfg), .protect_cfg(protect_cfg),
        .boot_done(boot_done));

    fcsr_host_model host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .sclk(sclk),
        .cs_n(cs_n), .dq_in(dq_in));

    task automatic final_report();
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd8(input logic [7:0] op, input logic [7:0] exp);
        host.xfer(op, 0, 16'h0000, 8, rd);
        chk(23'(rd[7:0]), 23'(exp));
    endtask

    task automatic wr8(input logic [7:0] op, input logic [7:0] d);
        host.xfer(op, 8, {d, 8'h00}, 0, rd);
    endtask

    task automatic cmd(input logic [7:0] op);
        host.xfer(op, 0, 16'h0000, 0, rd);
    endtask

    // Polls the busy flag; a cycle that never ends shows up as busy.
    task automatic wait_idle();
        int k;
        for (k = 0; k < 30; k++) begin
            host.xfer(`FCSR_OP_READ_STATUS_CMD, 0, 16'h0000, 8, rd);
            if (rd[0] === 1'b0) begin
                break;
            end
        end
        chk(23'(rd[0]), 23'h0);
    endtask

    task automatic vol(input logic [7:0] v, input logic [3:0] dum,
                       input logic [7:0] back);
        wr8(`FCSR_OP_WRVC, v);
        chk(23'(working_cfg.dummy), 23'(dum));
        chk(23'(working_cfg.xip_vol_n), 23'(v[3]));
        rd8(`FCSR_OP_RDVC, back);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            $display("ERROR t=%0t run did not finish", $time);
            final_report();
        end
    end

    initial begin
        int k;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(23'(working_cfg), 23'({4'hf, 3'h7, 1'b1, 3'h7, 1'b1,
            FCSR_PROTO_EXT, 8'hff}));
        chk(23'(protect_cfg), 23'h0);
        for (k = 0; k < 400 && boot_done !== 1'b1; k++) begin
            @(posedge clk);
        end
        chk(23'(boot_done), 23'h1);
        host.xfer(`FCSR_OP_RDNV, 0, 16'h0000, 16, rd);
        chk(23'(rd), 23'hffff);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'h00);
        chk(23'(host.oe_seen), 23'h2);
        chk(23'(dq_oe), 23'h0);
        wr8(`FCSR_OP_WRITE_STATUS_CMD, 8'ha4);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'h00);
        cmd(`FCSR_OP_WRITE_ENABLE_CMD);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'h02);
        wr8(`FCSR_OP_WRITE_STATUS_CMD, 8'ha4);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'h03);
        wait_idle();
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'ha4);
        chk(23'(protect_cfg), 23'h23);
        wp_n <= 1'b0;
        cmd(`FCSR_OP_WRITE_ENABLE_CMD);
        wr8(`FCSR_OP_WRITE_STATUS_CMD, 8'h00);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'ha6);
        cmd(`FCSR_OP_ERASE);
        rd8(`FCSR_OP_RDFLAG, 8'ha2);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'ha6);
        wp_n <= 1'b1;
        wr8(`FCSR_OP_WRITE_STATUS_CMD, 8'h00);
        wait_idle();
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'h00);
        cmd(`FCSR_OP_WRITE_ENABLE_CMD);
        cmd(`FCSR_OP_ERASE);
        rd8(`FCSR_OP_RDFLAG, 8'h00);
        wait_idle();
        rd8(`FCSR_OP_RDFLAG, 8'h80);
        vol(8'h08, 4'hf, 8'h08);
        vol(8'h57, 4'h5, 8'h50);
        wr8(`FCSR_OP_WRVE, 8'h3c);
        chk(23'(working_cfg.enh), 23'h3c);
        rd8(`FCSR_OP_RDVE, 8'h3c);
        cmd(`FCSR_OP_WRITE_ENABLE_CMD);
        host.xfer(`FCSR_OP_WRNV, 16, 16'hf30f, 0, rd);
        host.wt(250);
        rd8(`FCSR_OP_READ_STATUS_CMD, 8'h03);
        wait_idle();
        host.xfer(`FCSR_OP_RDNV, 0, 16'h0000, 16, rd);
        chk(23'(rd), 23'hf30f);
        chk(23'(working_cfg.proto), 23'(FCSR_PROTO_EXT));
        final_report();
    end
endmodule

// File: design/fcsr_cfg.svh
/*
 * Constants of the flash configuration and status register bank: field
 * positions, reset values, instruction codes and timing counts.
 * Assumes a 25 MHz system clock; included by the top and the bench.
 */
// Behaviour
// R1 - At boot the working configuration is loaded from the startup config register.
// R2 - Volatile and enhanced volatile writes are copied into the working config at once.
// R3 - Startup config is 16 bits; volatile and enhanced volatile are 8 bits.
// R4 - An 8-bit flag status register reports errors and a running cycle.
// R5 - Every register has read and write instructions in all three line protocols; the flag status register has a read instruction only.
// R6 - A startup config write runs a long internal flash-cell write cycle.
// R7 - The busy flag is 1 during status write, program or erase, else 0.
// R8 - Write enable latch is shown; while 0 status write, program, erase are rejected.
// R9 - Four non-volatile block protect bits, written by status write, guard a region.
// R10 - Whole array erase runs only when all block protect bits are 0.
// R11 - The region side bit changes only after a write enable instruction.
// R12 - Region side 0 anchors protection at the top, 1 at the bottom.
// R13 - Write disable bit with protect pin low freezes protection and refuses status writes.
// R14 - The startup config register holds all ones as delivered.
// R15 - The startup config register has its own read and write instructions.
// R16 - Bits 15..12 set dummy cycles 1..14; code 0 acts as code 15.
// R17 - Bits 11..9 select the address-only startup read mode, 111 disables it.
// R18 - Bits 8..6 select the output drive impedance, 111 is the default.
// R19 - Bit 5 cleared gives a fast boot with reads only; set gives full boot.
// R20 - Bit 4 cleared disables the hold function of the shared hold data pin.
// R21 - Bit 3 cleared starts the device in the quad line protocol.
// R22 - Bit 2 cleared starts the device in the dual line protocol.
// R23 - With bits 3 and 2 both cleared the device starts in quad.
// R24 - The write enable latch clears when a write, program or erase cycle ends.
`ifndef FCSR_CFG_SVH
`define FCSR_CFG_SVH

`define FCSR_CLK_NS 40
`define FCSR_FULL_BOOT_NS 700000
`define FCSR_FAST_BOOT_NS 100000
`define FCSR_FULL_BOOT_CYC (`FCSR_FULL_BOOT_NS / `FCSR_CLK_NS)
`define FCSR_FAST_BOOT_CYC (`FCSR_FAST_BOOT_NS / `FCSR_CLK_NS)
`define FCSR_SR_WRITE_CYC 64
`define FCSR_NV_WRITE_CYC 512
`define FCSR_ERASE_CYC 2048

`define FCSR_NONVOLATILE_STARTUP_CONFIG_RST 16'hffff
`define FCSR_VCR_RST 8'hf8
`define FCSR_VOLATILE_ENHANCED_CONFIG_RST 8'hff
`define FCSR_NV_DUMMY 15:12
`define FCSR_NV_XIP 11:9
`define FCSR_NV_DRIVE 8:6
`define FCSR_NV_FASTBOOT 5
`define FCSR_NV_HOLD 4
`define FCSR_NV_QUAD 3
`define FCSR_NV_DUAL 2
`define FCSR_VC_DUMMY 7:4
`define FCSR_VC_XIP 3

`define FCSR_OP_WRITE_ENABLE_CMD 8'h06
`define FCSR_OP_READ_STATUS_CMD 8'h05
`define FCSR_OP_WRITE_STATUS_CMD 8'h01
`define FCSR_OP_RDFLAG 8'h70
`define FCSR_OP_RDNV 8'hb5
`define FCSR_OP_WRNV 8'hb1
`define FCSR_OP_RDVC 8'h85
`define FCSR_OP_WRVC 8'h81
`define FCSR_OP_RDVE 8'h65
`define FCSR_OP_WRVE 8'h61
`define FCSR_OP_ERASE 8'hc7

`endif

// File: design/fcsr_pkg.sv
/*
 * Types of the flash configuration and status register bank.
 * Assumes the constants header is available on the include path.
 */
package fcsr_pkg;
    typedef enum logic [1:0] {
        FCSR_PROTO_EXT = 2'b00,
        FCSR_PROTO_DUAL = 2'b01,
        FCSR_PROTO_QUAD = 2'b10
    } fcsr_proto_e;

    typedef enum logic [2:0] {
        FCSR_LK_IDLE = 3'b000,
        FCSR_LK_CMD = 3'b001,
        FCSR_LK_WR = 3'b010,
        FCSR_LK_RD = 3'b011,
        FCSR_LK_SKIP = 3'b100
    } fcsr_link_e;

    typedef enum logic [1:0] {
        FCSR_CYC_NONE = 2'b00,
        FCSR_CYC_SR = 2'b01,
        FCSR_CYC_NV = 2'b10,
        FCSR_CYC_ERASE = 2'b11
    } fcsr_cyc_e;

    typedef struct packed {
        logic [3:0] dummy;
        logic [2:0] xip_mode;
        logic xip_vol_n;
        logic [2:0] drive;
        logic hold_en;
        fcsr_proto_e proto;
        logic [7:0] enh;
    } fcsr_work_s;

    typedef struct packed {
        logic status_write_disable;
        logic [3:0] bp;
        logic tb;
    } fcsr_prot_s;
endpackage

// File: design/fcsr_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes each bit changes slowly against the sampling clock.
 */
`timescale 1ns/1ps
module fcsr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// File: design/fcsr_top.sv
/*
 * Flash configuration and status register bank with its serial command
 * front end. Assumes the serial clock is slower than a quarter of clk.
 */
`timescale 1ns/1ps
`include "fcsr_cfg.svh"
module fcsr_top #(
    parameter int unsigned FULL_BOOT_CYC = `FCSR_FULL_BOOT_CYC,
    parameter int unsigned FAST_BOOT_CYC = `FCSR_FAST_BOOT_CYC,
    parameter int unsigned SR_WRITE_CYC = `FCSR_SR_WRITE_CYC,
    parameter int unsigned NV_WRITE_CYC = `FCSR_NV_WRITE_CYC,
    parameter int unsigned ERASE_CYC = `FCSR_ERASE_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic [3:0] dq_in,
    output logic [3:0] dq_out,
    output logic [3:0] dq_oe,
    output fcsr_pkg::fcsr_work_s working_cfg,
    output fcsr_pkg::fcsr_prot_s protect_cfg,
    output logic boot_done
);
    import fcsr_pkg::*;

    function automatic logic [3:0] fcsr_dummy(input logic [3:0] code);
        fcsr_dummy = (code == 4'h0) ? 4'hf : code;
    endfunction

    function automatic logic [4:0] fcsr_lanes(input fcsr_proto_e p);
        unique case (p)
            FCSR_PROTO_QUAD: fcsr_lanes = 5'h4;
            FCSR_PROTO_DUAL: fcsr_lanes = 5'h2;
            FCSR_PROTO_EXT: fcsr_lanes = 5'h1;
            default: fcsr_lanes = 5'h1;
        endcase
    endfunction

    function automatic logic [15:0] fcsr_shift(input logic [15:0] s,
                                               input logic [3:0] d,
                                               input fcsr_proto_e p);
        unique case (p)
            FCSR_PROTO_QUAD: fcsr_shift = {s[11:0], d};
            FCSR_PROTO_DUAL: fcsr_shift = {s[13:0], d[1:0]};
            FCSR_PROTO_EXT: fcsr_shift = {s[14:0], d[0]};
            default: fcsr_shift = {s[14:0], d[0]};
        endcase
    endfunction

    // Single-line replies leave on the second data line.
    function automatic logic [3:0] fcsr_drive(input logic [15:0] w,
                                              input fcsr_proto_e p);
        unique case (p)
            FCSR_PROTO_QUAD: fcsr_drive = w[15:12];
            FCSR_PROTO_DUAL: fcsr_drive = {2'h0, w[15:14]};
            FCSR_PROTO_EXT: fcsr_drive = {2'h0, w[15], 1'b0};
            default: fcsr_drive = {2'h0, w[15], 1'b0};
        endcase
    endfunction

    function automatic logic [4:0] fcsr_wlen(input logic [7:0] op);
        case (op)
            `FCSR_OP_WRNV: fcsr_wlen = 5'h10;
            `FCSR_OP_WRITE_STATUS_CMD, `FCSR_OP_WRVC, `FCSR_OP_WRVE: fcsr_wlen = 5'h8;
            default: fcsr_wlen = 5'h0;
        endcase
    endfunction

    logic [6:0] pin_s;
    logic sclk_q_r, cs_q_r;
    logic sclk_rise_c, sclk_fall_c, cs_fall_c, cs_rise_c, hold_c;
    logic [19:0] boot_cnt_r;
    logic read_ok_r, boot_done_r;
    fcsr_work_s work_r;
    fcsr_link_e lk_r, lk_dec_c;
    logic [7:0] cmd_r;
    logic [15:0] sh_r, sh_nxt, out_r, rd_val_c;
    logic [4:0] cnt_r, cnt_nxt, lanes_c;
    logic [31:0] rot_c;
    logic [15:0] nonvolatile_startup_config_r, pend_r;
    logic [7:0] vcr_r, volatile_enhanced_config_r, sr_c, fsr_c;
    fcsr_prot_s prot_r;
    logic wel_r, err_prot_r, busy_c, hw_prot_c, exec_c;
    fcsr_cyc_e cyc_r;
    logic [19:0] cyc_cnt_r;

    fcsr_sync #(.W(7)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({sclk, cs_n, wp_n, dq_in}),
        .q(pin_s)
    );

    // The synchroniser clears to 0, so the select edge detector does too.
    // A reset value of 1 here would see a false select after release.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b0;
        end else begin
            sclk_q_r <= pin_s[6];
            cs_q_r <= pin_s[5];
        end
    end

    // The shared pin pauses the bus only outside quad mode.
    assign hold_c = work_r.hold_en && work_r.proto != FCSR_PROTO_QUAD &&
                    !pin_s[3] && !pin_s[5]; // [R20]
    assign sclk_rise_c = pin_s[6] && !sclk_q_r && !hold_c;
    assign sclk_fall_c = !pin_s[6] && sclk_q_r && !hold_c;
    assign cs_fall_c = !pin_s[5] && cs_q_r;
    assign cs_rise_c = pin_s[5] && !cs_q_r;
    assign hw_prot_c = prot_r.status_write_disable && !pin_s[4]; // [R13]
    assign busy_c = cyc_r != FCSR_CYC_NONE; // [R7]
    assign sr_c = {prot_r.status_write_disable, prot_r.bp[3], prot_r.tb, prot_r.bp[2:0],
                   wel_r, busy_c}; // [R8] [R9] [R12]
    assign fsr_c = {!busy_c, 1'b0, err_prot_r, 3'h0, err_prot_r, 1'b0}; // [R4]
    assign lanes_c = fcsr_lanes(work_r.proto);
    assign sh_nxt = fcsr_shift(sh_r, pin_s[3:0], work_r.proto);
    assign cnt_nxt = cnt_r + lanes_c;
    assign rot_c = {out_r, out_r} << lanes_c;
    assign exec_c = cs_rise_c && lk_r == FCSR_LK_WR &&
                    cnt_r == fcsr_wlen(cmd_r);

    // A fast boot opens reads early; writes still wait for the full boot.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_cnt_r <= 20'h0;
            read_ok_r <= 1'b0;
            boot_done_r <= 1'b0;
        end else if (!boot_done_r) begin
            boot_cnt_r <= boot_cnt_r + 20'h1;
            if (boot_cnt_r == 20'(FAST_BOOT_CYC - 1) &&
                !nonvolatile_startup_config_r[`FCSR_NV_FASTBOOT]) begin
                read_ok_r <= 1'b1; // [R19]
            end
            if (boot_cnt_r == 20'(FULL_BOOT_CYC - 1)) begin
                read_ok_r <= 1'b1;
                boot_done_r <= 1'b1; // [R19]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            work_r <= '{dummy: 4'hf, xip_mode: 3'h7, xip_vol_n: 1'b1,
                        drive: 3'h7, hold_en: 1'b1, proto: FCSR_PROTO_EXT,
                        enh: `FCSR_VOLATILE_ENHANCED_CONFIG_RST};
        end else if (boot_cnt_r == 20'h0 && !boot_done_r) begin
            work_r.dummy <= fcsr_dummy(nonvolatile_startup_config_r[`FCSR_NV_DUMMY]); // [R1] [R16]
            work_r.xip_mode <= nonvolatile_startup_config_r[`FCSR_NV_XIP]; // [R17]
            work_r.drive <= nonvolatile_startup_config_r[`FCSR_NV_DRIVE]; // [R18]
            work_r.hold_en <= nonvolatile_startup_config_r[`FCSR_NV_HOLD]; // [R20]
            if (!nonvolatile_startup_config_r[`FCSR_NV_QUAD]) begin
                work_r.proto <= FCSR_PROTO_QUAD; // [R21] [R23]
            end else if (!nonvolatile_startup_config_r[`FCSR_NV_DUAL]) begin
                work_r.proto <= FCSR_PROTO_DUAL; // [R22]
            end else begin
                work_r.proto <= FCSR_PROTO_EXT;
            end
        end else if (exec_c && cmd_r == `FCSR_OP_WRVC) begin
            work_r.dummy <= fcsr_dummy(sh_r[`FCSR_VC_DUMMY]); // [R2]
            work_r.xip_vol_n <= sh_r[`FCSR_VC_XIP]; // [R2]
        end else if (exec_c && cmd_r == `FCSR_OP_WRVE) begin
            work_r.enh <= sh_r[7:0]; // [R2]
        end
    end

    // Only the two polling reads are served while a cycle runs.
    always_comb begin
        lk_dec_c = FCSR_LK_SKIP;
        rd_val_c = 16'h0;
        case (sh_nxt[7:0])
            `FCSR_OP_READ_STATUS_CMD: begin
                lk_dec_c = FCSR_LK_RD;
                rd_val_c = {sr_c, sr_c};
            end
            `FCSR_OP_RDFLAG: begin
                lk_dec_c = FCSR_LK_RD;
                rd_val_c = {fsr_c, fsr_c};
            end
            `FCSR_OP_RDNV: begin
                lk_dec_c = busy_c ? FCSR_LK_SKIP : FCSR_LK_RD; // [R15]
                rd_val_c = {nonvolatile_startup_config_r[7:0], nonvolatile_startup_config_r[15:8]};
            end
            `FCSR_OP_RDVC: begin
                lk_dec_c = busy_c ? FCSR_LK_SKIP : FCSR_LK_RD;
                rd_val_c = {vcr_r, vcr_r};
            end
            `FCSR_OP_RDVE: begin
                lk_dec_c = busy_c ? FCSR_LK_SKIP : FCSR_LK_RD;
                rd_val_c = {volatile_enhanced_config_r, volatile_enhanced_config_r};
            end
            `FCSR_OP_WRITE_ENABLE_CMD, `FCSR_OP_WRITE_STATUS_CMD, `FCSR_OP_WRNV, `FCSR_OP_WRVC,
            `FCSR_OP_WRVE, `FCSR_OP_ERASE: begin
                lk_dec_c = (boot_done_r && !busy_c) ? FCSR_LK_WR
                                                   : FCSR_LK_SKIP; // [R19]
            end
            default: begin
                lk_dec_c = FCSR_LK_SKIP;
            end
        endcase
    end

    // Same framing in every protocol; only the lane count differs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lk_r <= FCSR_LK_IDLE;
            cmd_r <= 8'h0;
            sh_r <= 16'h0;
            cnt_r <= 5'h0;
            out_r <= 16'h0;
            dq_out <= 4'h0;
            dq_oe <= 4'h0;
        end else if (cs_rise_c) begin
            lk_r <= FCSR_LK_IDLE;
            dq_oe <= 4'h0;
        end else begin
            unique case (lk_r)
                FCSR_LK_IDLE: begin
                    if (cs_fall_c) begin
                        lk_r <= read_ok_r ? FCSR_LK_CMD : FCSR_LK_SKIP;
                        cnt_r <= 5'h0;
                        sh_r <= 16'h0;
                    end
                end
                FCSR_LK_CMD: begin
                    if (sclk_rise_c) begin
                        sh_r <= sh_nxt;
                        cnt_r <= cnt_nxt;
                        if (cnt_nxt == 5'h8) begin
                            cmd_r <= sh_nxt[7:0]; // [R5]
                            lk_r <= lk_dec_c;
                            out_r <= rd_val_c;
                            sh_r <= 16'h0;
                            cnt_r <= 5'h0;
                        end
                    end
                end
                FCSR_LK_WR: begin
                    if (sclk_rise_c) begin
                        if (cnt_r >= 5'h10) begin
                            lk_r <= FCSR_LK_SKIP;
                        end else begin
                            sh_r <= sh_nxt;
                            cnt_r <= cnt_nxt;
                        end
                    end
                end
                FCSR_LK_RD: begin
                    if (sclk_fall_c) begin
                        dq_out <= fcsr_drive(out_r, work_r.proto); // [R5]
                        dq_oe <= fcsr_drive(16'hffff, work_r.proto);
                        out_r <= rot_c[31:16];
                    end
                end
                FCSR_LK_SKIP: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nonvolatile_startup_config_r <= `FCSR_NONVOLATILE_STARTUP_CONFIG_RST; // [R14]
            vcr_r <= `FCSR_VCR_RST;
            volatile_enhanced_config_r <= `FCSR_VOLATILE_ENHANCED_CONFIG_RST;
            prot_r <= '0;
            pend_r <= 16'h0;
            wel_r <= 1'b0;
            err_prot_r <= 1'b0;
            cyc_r <= FCSR_CYC_NONE;
            cyc_cnt_r <= 20'h0;
        end else if (busy_c) begin
            if (cyc_cnt_r == 20'h1) begin
                if (cyc_r == FCSR_CYC_SR) begin
                    prot_r <= '{status_write_disable: pend_r[7], bp: {pend_r[6], pend_r[4:2]},
                                tb: pend_r[5]}; // [R9] [R11]
                end
                if (cyc_r == FCSR_CYC_NV) begin
                    nonvolatile_startup_config_r <= pend_r; // [R6]
                end
                cyc_r <= FCSR_CYC_NONE;
                wel_r <= 1'b0; // [R24]
            end else begin
                cyc_cnt_r <= cyc_cnt_r - 20'h1;
            end
        end else if (exec_c) begin
            case (cmd_r)
                `FCSR_OP_WRITE_ENABLE_CMD: begin
                    wel_r <= 1'b1; // [R11]
                end
                `FCSR_OP_WRITE_STATUS_CMD: begin
                    if (wel_r && !hw_prot_c) begin // [R8] [R13]
                        cyc_r <= FCSR_CYC_SR;
                        cyc_cnt_r <= 20'(SR_WRITE_CYC);
                        pend_r <= {8'h0, sh_r[7:0]};
                    end
                end
                `FCSR_OP_WRNV: begin
                    if (wel_r) begin // [R8]
                        cyc_r <= FCSR_CYC_NV; // [R6]
                        cyc_cnt_r <= 20'(NV_WRITE_CYC);
                        pend_r <= {sh_r[7:0], sh_r[15:8]}; // [R3] [R15]
                    end
                end
                `FCSR_OP_WRVC: begin
                    vcr_r <= {sh_r[7:3], 3'h0}; // [R3]
                end
                `FCSR_OP_WRVE: begin
                    volatile_enhanced_config_r <= sh_r[7:0];
                end
                `FCSR_OP_ERASE: begin
                    if (wel_r && prot_r.bp == 4'h0) begin // [R8] [R10]
                        cyc_r <= FCSR_CYC_ERASE;
                        cyc_cnt_r <= 20'(ERASE_CYC);
                        err_prot_r <= 1'b0;
                    end else if (wel_r) begin
                        err_prot_r <= 1'b1; // [R4]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign working_cfg = work_r;
    assign protect_cfg = prot_r;
    assign boot_done = boot_done_r;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_nv_start;
        exec_c && cmd_r == `FCSR_OP_WRNV && wel_r;
    endsequence
    sequence s_boot_load;
        boot_cnt_r == 20'h0 && !boot_done_r;
    endsequence

    a_boot_cfg_load: assert property (s_boot_load |=> // [R1]
        work_r.drive == $past(nonvolatile_startup_config_r[8:6]) &&
        work_r.hold_en == $past(nonvolatile_startup_config_r[4]))
        else $error("working config not loaded at boot");
    a_quad_first: assert property (s_boot_load ##0 !nonvolatile_startup_config_r[3] |=> // [R23]
        work_r.proto == FCSR_PROTO_QUAD)
        else $error("quad start bit ignored");
    a_vol_copy: assert property ( // [R2]
        exec_c && cmd_r == `FCSR_OP_WRVC |=>
        work_r.dummy == fcsr_dummy($past(sh_r[7:4])))
        else $error("volatile write not copied to working config");
    a_nv_long_busy: assert property (s_nv_start |=> busy_c[*8]) // [R6]
        else $error("startup config write cycle too short");
    a_wel_gate: assert property (exec_c && !wel_r && // [R8]
        (cmd_r == `FCSR_OP_WRITE_STATUS_CMD || cmd_r == `FCSR_OP_WRNV ||
         cmd_r == `FCSR_OP_ERASE) |=> !busy_c)
        else $error("modifying instruction ran without write enable");
    a_erase_guard: assert property ( // [R10]
        exec_c && cmd_r == `FCSR_OP_ERASE && prot_r.bp != 4'h0 |=>
        !busy_c && (err_prot_r || !$past(wel_r)))
        else $error("erase ran with protect bits set");
    a_hw_protect: assert property ( // [R13]
        exec_c && cmd_r == `FCSR_OP_WRITE_STATUS_CMD && hw_prot_c |=> !busy_c ##1
        $stable(prot_r))
        else $error("status write accepted in protected mode");
    a_wel_clear: assert property ( // [R24]
        busy_c && cyc_cnt_r == 20'h1 |=> !wel_r && sr_c[0] == 1'b0)
        else $error("write enable latch not cleared after cycle");
    a_side_bit: assert property ($changed(prot_r.tb) |-> // [R11]
        $past(cyc_r) == FCSR_CYC_SR)
        else $error("region side bit changed outside status write");
    a_dummy_code: assert property (work_r.dummy != 4'h0) // [R16]
        else $error("dummy count code zero in working config");
endmodule
